// [bench/aad_detect_cfg_tb_top.sv]
// Self-checking testbench of the activity detection configuration block
`timescale 1ns/100ps
module aad_detect_cfg_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  aad_pkg::aad_write_s wr;
  logic pdm_clock_running;
  aad_pkg::aad_level_s level = '0;
  logic analog_above_level = 1'b0;
  logic analog_below_cutoff = 1'b0;
  logic activity_flag;
  logic [2:0] analog_cutoff_select;
  logic [3:0] analog_level_select;
  logic pdm_stream_on;
  logic digital_detector_active;
  logic analog_detector_active;
  int num_errors = 0;
  int checked = 0;

  initial begin
    forever #50 clk = ~clk;
  end

  aad_host_model i_host (
    .clk(clk),
    .wr(wr),
    .pdm_clock_running(pdm_clock_running)
  );

  aad_detect_cfg #(
    .AVG_SHIFT(2)
  ) i_dut (
    .clk(clk),
    .reset(reset),
    .wr(wr),
    .pdm_clock_running(pdm_clock_running),
    .level(level),
    .analog_above_level(analog_above_level),
    .analog_below_cutoff(analog_below_cutoff),
    .activity_flag(activity_flag),
    .analog_cutoff_select(analog_cutoff_select),
    .analog_level_select(analog_level_select),
    .pdm_stream_on(pdm_stream_on),
    .digital_detector_active(digital_detector_active),
    .analog_detector_active(analog_detector_active)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic mode_chk(input logic [2:0] exp);
    settle;
    check("mode", exp, {pdm_stream_on, digital_detector_active, analog_detector_active});
  endtask

  task automatic sample_chk(input logic [12:0] v, input logic exp);
    @(negedge clk);
    level.valid = 1'b1;
    level.value = v;
    @(negedge clk);
    level.valid = 1'b0;
    level.value = ~v;
    settle;
    check("activity_flag", exp, activity_flag);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #2000000;
    num_errors++;
    end_of_test;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("reset outputs", 16'h0000, {activity_flag, analog_cutoff_select,
      analog_level_select, pdm_stream_on, digital_detector_active,
      analog_detector_active});
    reset = 1'b0;
    i_host.write_reg(aad_pkg::REG_ANALOG_CUTOFF_SEL, 8'hF9);
    i_host.write_reg(aad_pkg::REG_ANALOG_LEVEL_SEL, 8'hF4);
    i_host.write_reg(aad_pkg::REG_RESERVED_A, 8'hFF);
    i_host.write_reg(aad_pkg::REG_RESERVED_B, 8'hFF);
    settle;
    check("cutoff_select", 16'h0001, analog_cutoff_select);
    check("level_select", 16'h0004, analog_level_select);
    i_host.write_reg(aad_pkg::REG_DETECT_ENABLE_CTRL, 8'hF8);
    mode_chk(3'b000);
    i_host.set_clock(1'b0);
    mode_chk(3'b001);
    for (int i = 0; i < 4; i++) begin
      analog_above_level = i[1];
      analog_below_cutoff = i[0];
      settle;
      check("analog flag", i == 3, activity_flag);
    end
    analog_above_level = 1'b0;
    // Variant select against clock presence
    for (int c = 0; c < 2; c++) begin
      i_host.set_clock(c[0]);
      for (int v = 0; v < 4; v++) begin
        i_host.write_reg(aad_pkg::REG_DETECT_ENABLE_CTRL, 8'h04 | v[7:0]);
        mode_chk({v == 1 && c == 1, (v == 1 && c == 1) || v == 2, 1'b0});
      end
    end
    // Absolute algorithm alone: relative fixed threshold held out of reach
    i_host.write_reg(aad_pkg::REG_ABS_LEVEL_LOWER, 8'h13);
    i_host.write_reg(aad_pkg::REG_ABS_LEVEL_UPPER, 8'hE1);
    i_host.write_reg(aad_pkg::REG_FLOOR_UPPER, 8'h07);
    i_host.write_reg(aad_pkg::REG_FLOOR_LOWER, 8'hBC);
    i_host.write_reg(aad_pkg::REG_RELATIVE_MARGIN, 8'hFF);
    i_host.write_reg(aad_pkg::REG_REL_PULSE_LOWER, 8'h00);
    i_host.write_reg(aad_pkg::REG_PULSE_UPPER_SHARED, 8'h00);
    i_host.write_reg(aad_pkg::REG_ABS_PULSE_LOWER, 8'h00);
    for (int v = 1; v < 3; v++) begin
      i_host.write_reg(aad_pkg::REG_DETECT_ENABLE_CTRL, v[7:0]);
      settle;
      sample_chk(13'h0113, 1'b0);
      sample_chk(13'h0200, 1'b1);
      sample_chk(13'h0114, 1'b1);
      sample_chk(13'h0010, 1'b0);
    end
    i_host.write_reg(aad_pkg::REG_ABS_PULSE_LOWER, 8'h02);
    sample_chk(13'h0200, 1'b0);
    sample_chk(13'h0200, 1'b0);
    sample_chk(13'h0200, 1'b1);
    sample_chk(13'h0010, 1'b0);
    // Relative algorithm alone, fresh background average
    i_host.write_reg(aad_pkg::REG_DETECT_ENABLE_CTRL, 8'h00);
    i_host.write_reg(aad_pkg::REG_ABS_LEVEL_UPPER, 8'h07);
    i_host.write_reg(aad_pkg::REG_ABS_LEVEL_LOWER, 8'hBC);
    i_host.write_reg(aad_pkg::REG_FLOOR_UPPER, 8'h00);
    i_host.write_reg(aad_pkg::REG_FLOOR_LOWER, 8'h0F);
    i_host.write_reg(aad_pkg::REG_RELATIVE_MARGIN, 8'h24);
    i_host.write_reg(aad_pkg::REG_REL_PULSE_LOWER, 8'h01);
    i_host.write_reg(aad_pkg::REG_DETECT_ENABLE_CTRL, 8'h02);
    settle;
    // Two samples just under floor plus margin: a tracking threshold would fire here
    sample_chk(13'h0032, 1'b0);
    sample_chk(13'h0032, 1'b0);
    sample_chk(13'h0100, 1'b0);
    sample_chk(13'h0100, 1'b1);
    // Average climbs toward the steady level until average plus margin passes it
    for (int i = 0; i < 19; i++) begin
      sample_chk(13'h0100, i < 5);
    end
    sample_chk(13'h0100, 1'b0);
    // Reset in mid-run clears everything
    @(negedge clk);
    reset = 1'b1;
    settle;
    check("reset outputs", 16'h0000, {activity_flag, analog_cutoff_select,
      analog_level_select, pdm_stream_on, digital_detector_active,
      analog_detector_active});
    reset = 1'b0;
    i_host.write_reg(aad_pkg::REG_DETECT_ENABLE_CTRL, 8'h01);
    mode_chk(3'b110);
    end_of_test;
  end
endmodule

// [bench/aad_host_model.sv]
// Host controller model: one-wire register writes and PDM clock control
`timescale 1ns/100ps
module aad_host_model (
  // Clock
  input wire logic clk,
  // Host side of the device
  output aad_pkg::aad_write_s wr,
  output logic pdm_clock_running
);
  initial begin
    wr = '0;
    pdm_clock_running = 1'b1;
  end

  // ----------------------------------------------------------------
  // Host actions
  // ----------------------------------------------------------------
  // Settings travel only as decoded one-wire writes
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    wr.valid = 1'b1;
    wr.addr = addr;
    wr.data = data;
    @(negedge clk);
    wr.valid = 1'b0;
    wr.addr = ~addr;
    wr.data = ~data;
  endtask

  // Clock changes on the next falling edge, whatever settings and enables are in place
  task automatic set_clock(input logic on);
    @(negedge clk);
    pdm_clock_running = on;
  endtask
endmodule

// [logic/aad_detect_cfg.sv]
// Configuration registers and wake decision of the acoustic activity detector
`timescale 1ns/100ps

// Notes on behaviour
// - Analog detector is active only when enabled and the PDM clock is stopped.
// - Register 0x29 bits 1:0 pick clocked (1) or clockless (2) digital variant.
// - Clocked variant keeps the PDM bitstream on; clockless variant turns it off.
// - Both digital variants share registers and detect in exactly the same way.
// - Settings arrive only as one-wire writes; results leave only on the flag.
// - Floor is 0x2A[4:0] upper and 0x2B[7:0] lower; host keeps 0x0F..0x7BC.
// - Relative duration is 0x2F[3:0] upper, 0x2E lower; host keeps up to 0x12C.
// - Absolute duration is 0x2F[7:4] upper, 0x30 lower; host keeps up to 0xDAA.
// - Absolute level is 0x32[4:0] upper and 0x31 lower; host keeps 0x00F..0x7BC.
// - Relative margin is all of 0x33; host keeps 0x24..0xFF.
// - Detection qualifies only when level exceeds threshold for the minimum duration.
// - Absolute and relative algorithms run together; either one raises the flag.
// - Flag rises on qualified stimulus, holds while it lasts, falls when it stops.
// - Relative algorithm keeps a running background average and adds the margin.
// - Below floor plus margin threshold is fixed, otherwise average plus margin.
// - Register 0x29 bit 3 turns the analog detector on; it resets off.
// - Analog cutoff select is 0x35[2:0]; analog level select is 0x36[3:0].
// - Analog detector flags while above level and below cutoff, else drops it.
module aad_detect_cfg #(
  parameter int AVG_SHIFT = aad_pkg::AVG_SHIFT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Decoded one-wire register writes
  input wire aad_pkg::aad_write_s wr,
  // Host clock presence
  input wire logic pdm_clock_running,
  // Voice-band filtered level samples
  input wire aad_pkg::aad_level_s level,
  // Analog comparator results
  input wire logic analog_above_level,
  input wire logic analog_below_cutoff,
  // Activity flag pin
  output logic activity_flag,
  // Analog path controls
  output logic [2:0] analog_cutoff_select,
  output logic [3:0] analog_level_select,
  // Mode status
  output logic pdm_stream_on,
  output logic digital_detector_active,
  output logic analog_detector_active
);

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [1:0] digital_variant_select;
  logic analog_detector_on;
  logic [4:0] floor_upper;
  logic [7:0] floor_lower;
  logic [7:0] rel_pulse_lower;
  logic [7:0] pulse_upper_shared;
  logic [7:0] abs_pulse_lower;
  logic [7:0] abs_level_lower;
  logic [4:0] abs_level_upper;
  logic [7:0] relative_margin;

  // Unmapped and reserved offsets fall to default and are dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      digital_variant_select <= aad_pkg::VARIANT_OFF;
      analog_detector_on <= 1'b0;
      floor_upper <= aad_pkg::UPPER5_ZERO;
      floor_lower <= aad_pkg::BYTE_ZERO;
      rel_pulse_lower <= aad_pkg::BYTE_ZERO;
      pulse_upper_shared <= aad_pkg::BYTE_ZERO;
      abs_pulse_lower <= aad_pkg::BYTE_ZERO;
      abs_level_lower <= aad_pkg::BYTE_ZERO;
      abs_level_upper <= aad_pkg::UPPER5_ZERO;
      relative_margin <= aad_pkg::BYTE_ZERO;
      analog_cutoff_select <= 3'h0;
      analog_level_select <= 4'h0;
    end else if (wr.valid) begin
      case (wr.addr)
        aad_pkg::REG_DETECT_ENABLE_CTRL: begin
          digital_variant_select <=
            wr.data[aad_pkg::VARIANT_MSB:aad_pkg::VARIANT_LSB];
          analog_detector_on <= wr.data[aad_pkg::ANALOG_ON_BIT];
        end
        aad_pkg::REG_FLOOR_UPPER: floor_upper <= wr.data[aad_pkg::UPPER5_MSB:0];
        aad_pkg::REG_FLOOR_LOWER: floor_lower <= wr.data;
        aad_pkg::REG_REL_PULSE_LOWER: rel_pulse_lower <= wr.data;
        aad_pkg::REG_PULSE_UPPER_SHARED: pulse_upper_shared <= wr.data;
        aad_pkg::REG_ABS_PULSE_LOWER: abs_pulse_lower <= wr.data;
        aad_pkg::REG_ABS_LEVEL_LOWER: abs_level_lower <= wr.data;
        aad_pkg::REG_ABS_LEVEL_UPPER: abs_level_upper <= wr.data[aad_pkg::UPPER5_MSB:0];
        aad_pkg::REG_RELATIVE_MARGIN: relative_margin <= wr.data;
        aad_pkg::REG_ANALOG_CUTOFF_SEL:
          analog_cutoff_select <= wr.data[aad_pkg::CUTOFF_MSB:0];
        aad_pkg::REG_ANALOG_LEVEL_SEL:
          analog_level_select <= wr.data[aad_pkg::ANALOG_LEVEL_MSB:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assembled fields
  // ----------------------------------------------------------------
  logic [12:0] floor_level;
  logic [12:0] absolute_level;
  logic [12:0] min_dur [2];

  assign floor_level = {floor_upper, floor_lower};
  assign absolute_level = {abs_level_upper, abs_level_lower};
  assign min_dur[0] = {1'b0, pulse_upper_shared[aad_pkg::ABS_UPPER_MSB:aad_pkg::ABS_UPPER_LSB],
    abs_pulse_lower};
  assign min_dur[1] = {1'b0, pulse_upper_shared[aad_pkg::REL_UPPER_MSB:0],
    rel_pulse_lower};

  function automatic logic [13:0] add_margin(input logic [12:0] base, input logic [7:0] margin);
    add_margin = {1'b0, base} + {6'h00, margin};
  endfunction

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  aad_pkg::aad_mode_e mode;
  aad_pkg::aad_mode_e next_mode;
  logic digital_mode;

  always_comb begin
    if (analog_detector_on && !pdm_clock_running) begin
      next_mode = aad_pkg::MODE_ANALOG;
    end else if (digital_variant_select == aad_pkg::VARIANT_CLOCKED && pdm_clock_running) begin
      next_mode = aad_pkg::MODE_CLOCKED;
    end else if (digital_variant_select == aad_pkg::VARIANT_CLOCKLESS) begin
      next_mode = aad_pkg::MODE_CLOCKLESS;
    end else begin
      next_mode = aad_pkg::MODE_OFF;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode <= aad_pkg::MODE_OFF;
      pdm_stream_on <= 1'b0;
      digital_detector_active <= 1'b0;
      analog_detector_active <= 1'b0;
    end else begin
      mode <= next_mode;
      pdm_stream_on <= (next_mode == aad_pkg::MODE_CLOCKED);
      digital_detector_active <= (next_mode == aad_pkg::MODE_CLOCKED) ||
        (next_mode == aad_pkg::MODE_CLOCKLESS);
      analog_detector_active <= (next_mode == aad_pkg::MODE_ANALOG);
    end
  end

  assign digital_mode = (mode == aad_pkg::MODE_CLOCKED) || (mode == aad_pkg::MODE_CLOCKLESS);

  // ----------------------------------------------------------------
  // Relative threshold
  // ----------------------------------------------------------------
  logic [12:0] background_avg;
  logic [12:0] next_avg;
  logic signed [13:0] avg_diff;
  logic signed [13:0] avg_step;
  logic [13:0] avg_sum;
  logic [13:0] fixed_thr;
  logic [13:0] tracking_thr;
  logic [13:0] inst_thr;
  logic above_thr [2];

  always_comb begin
    avg_diff = $signed({1'b0, level.value}) - $signed({1'b0, background_avg});
    avg_step = avg_diff >>> AVG_SHIFT;
    avg_sum = {1'b0, background_avg} + avg_step;
    next_avg = avg_sum[12:0];
    fixed_thr = add_margin(floor_level, relative_margin);
    tracking_thr = add_margin(background_avg, relative_margin);
    inst_thr = ({1'b0, level.value} < fixed_thr) ? fixed_thr : tracking_thr;
  end

  assign above_thr[0] = level.value > absolute_level;
  assign above_thr[1] = {1'b0, level.value} > inst_thr;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      background_avg <= aad_pkg::LEVEL_ZERO;
    end else if (!digital_mode) begin
      background_avg <= aad_pkg::LEVEL_ZERO;
    end else if (level.valid) begin
      background_avg <= next_avg;
    end
  end

  // ----------------------------------------------------------------
  // Minimum duration qualification, index 0 absolute, 1 relative
  // ----------------------------------------------------------------
  logic [12:0] run_cnt [2];
  logic qualified [2];

  for (genvar g = 0; g < 2; g++) begin : g_algo
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        run_cnt[g] <= aad_pkg::LEVEL_ZERO;
        qualified[g] <= 1'b0;
      end else if (!digital_mode) begin
        run_cnt[g] <= aad_pkg::LEVEL_ZERO;
        qualified[g] <= 1'b0;
      end else if (level.valid) begin
        if (above_thr[g]) begin
          run_cnt[g] <= (run_cnt[g] == aad_pkg::COUNT_MAX) ? run_cnt[g] : run_cnt[g] + 13'h0001;
          qualified[g] <= run_cnt[g] >= min_dur[g];
        end else begin
          run_cnt[g] <= aad_pkg::LEVEL_ZERO;
          qualified[g] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Activity flag
  // ----------------------------------------------------------------
  logic next_flag;

  always_comb begin
    unique case (mode)
      aad_pkg::MODE_ANALOG: next_flag = analog_above_level && analog_below_cutoff;
      aad_pkg::MODE_CLOCKED,
      aad_pkg::MODE_CLOCKLESS: next_flag = qualified[0] || qualified[1];
      aad_pkg::MODE_OFF: next_flag = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      activity_flag <= 1'b0;
    end else begin
      activity_flag <= next_flag;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  analog_activation_a: assert property (
    analog_detector_on && !pdm_clock_running |=> analog_detector_active && !pdm_stream_on)
    else $error("analog detector not activated with clock stopped");

  variant_write_a: assert property (
    wr.valid && wr.addr == aad_pkg::REG_DETECT_ENABLE_CTRL |=>
      digital_variant_select == $past(wr.data[1:0]))
    else $error("variant select not taken from write");

  clockless_stream_a: assert property (
    digital_variant_select == aad_pkg::VARIANT_CLOCKLESS && !analog_detector_on |=>
      digital_detector_active && !pdm_stream_on)
    else $error("clockless variant left bitstream on or idle");

  shared_flag_a: assert property (
    digital_mode |=> activity_flag == ($past(qualified[0]) || $past(qualified[1])))
    else $error("digital flag does not follow qualified detections");

  floor_write_a: assert property (
    wr.valid && wr.addr == aad_pkg::REG_FLOOR_LOWER |=> floor_level[7:0] == $past(wr.data))
    else $error("floor lower byte not stored");

  rel_duration_a: assert property (
    wr.valid && wr.addr == aad_pkg::REG_PULSE_UPPER_SHARED |=>
      min_dur[1][11:8] == $past(wr.data[3:0]))
    else $error("relative duration upper bits wrong");

  abs_duration_a: assert property (
    wr.valid && wr.addr == aad_pkg::REG_PULSE_UPPER_SHARED |=>
      min_dur[0][11:8] == $past(wr.data[7:4]))
    else $error("absolute duration upper bits wrong");

  abs_level_a: assert property (
    wr.valid && wr.addr == aad_pkg::REG_ABS_LEVEL_UPPER |=>
      absolute_level[12:8] == $past(wr.data[4:0]))
    else $error("absolute level upper bits wrong");

  margin_write_a: assert property (
    wr.valid && wr.addr == aad_pkg::REG_RELATIVE_MARGIN |=> relative_margin == $past(wr.data))
    else $error("relative margin not stored");

  qualify_duration_a: assert property (
    $rose(qualified[0]) |-> $past(run_cnt[0]) >= $past(min_dur[0]) && $past(above_thr[0]))
    else $error("absolute detection qualified too early");

  flag_drop_a: assert property (
    digital_mode && level.valid && !above_thr[0] && !above_thr[1] ##1 digital_mode |=>
      !activity_flag)
    else $error("flag held after stimulus fell");

  fixed_threshold_a: assert property (
    digital_mode && level.valid && {1'b0, level.value} < fixed_thr && !above_thr[0] |=>
      !qualified[1] && !qualified[0])
    else $error("relative detection below floor plus margin");

  analog_flag_a: assert property (
    mode == aad_pkg::MODE_ANALOG && !(analog_above_level && analog_below_cutoff) |=>
      !activity_flag)
    else $error("analog flag set outside conditions");

  reserved_write_a: assert property (
    wr.valid && (wr.addr == aad_pkg::REG_RESERVED_A || wr.addr == aad_pkg::REG_RESERVED_B) |=>
      $stable(floor_level) && $stable(absolute_level) && $stable(digital_variant_select))
    else $error("reserved write changed configuration");

  analog_wake_c: cover property (mode == aad_pkg::MODE_ANALOG ##1 activity_flag);
  clocked_wake_c: cover property (mode == aad_pkg::MODE_CLOCKED && $rose(activity_flag));
  clockless_rel_c: cover property (mode == aad_pkg::MODE_CLOCKLESS && $rose(qualified[1]));

endmodule

// [shared/aad_pkg.sv]
// Constants, types and register map of the activity detection configuration block
package aad_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_DETECT_ENABLE_CTRL = 8'h29;
  localparam logic [7:0] REG_FLOOR_UPPER = 8'h2A;
  localparam logic [7:0] REG_FLOOR_LOWER = 8'h2B;
  localparam logic [7:0] REG_RESERVED_A = 8'h2C;
  localparam logic [7:0] REG_RESERVED_B = 8'h2D;
  localparam logic [7:0] REG_REL_PULSE_LOWER = 8'h2E;
  localparam logic [7:0] REG_PULSE_UPPER_SHARED = 8'h2F;
  localparam logic [7:0] REG_ABS_PULSE_LOWER = 8'h30;
  localparam logic [7:0] REG_ABS_LEVEL_LOWER = 8'h31;
  localparam logic [7:0] REG_ABS_LEVEL_UPPER = 8'h32;
  localparam logic [7:0] REG_RELATIVE_MARGIN = 8'h33;
  localparam logic [7:0] REG_ANALOG_CUTOFF_SEL = 8'h35;
  localparam logic [7:0] REG_ANALOG_LEVEL_SEL = 8'h36;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int VARIANT_LSB = 0;
  localparam int VARIANT_MSB = 1;
  localparam int ANALOG_ON_BIT = 3;
  localparam int UPPER5_MSB = 4;
  localparam int REL_UPPER_MSB = 3;
  localparam int ABS_UPPER_LSB = 4;
  localparam int ABS_UPPER_MSB = 7;
  localparam int CUTOFF_MSB = 2;
  localparam int ANALOG_LEVEL_MSB = 3;
  localparam logic [1:0] VARIANT_CLOCKED = 2'h1;
  localparam logic [1:0] VARIANT_CLOCKLESS = 2'h2;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int LEVEL_W = 13;
  localparam int AVG_SHIFT = 4;
  localparam logic [12:0] COUNT_MAX = 13'h1FFF;
  localparam logic [12:0] LEVEL_ZERO = 13'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [4:0] UPPER5_ZERO = 5'h00;
  localparam logic [1:0] VARIANT_OFF = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_ANALOG = 2'b01,
    MODE_CLOCKED = 2'b10,
    MODE_CLOCKLESS = 2'b11
  } aad_mode_e;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } aad_write_s;

  typedef struct packed {
    logic valid;
    logic [12:0] value;
  } aad_level_s;

endpackage
